// ---- design/pplsp_pkg.sv ----
// Shared constants for the per-lane symbol port block
package pplsp_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int          PPLSP_LANES_DEF  = 8;
	localparam int          PPLSP_LANES_MAX  = 8;
	localparam int          PPLSP_WORD_W     = 16;
	localparam int          PPLSP_KIND_W     = 2;
	localparam int          PPLSP_COND_W     = 3;
	localparam int          PPLSP_PWR_W      = 2;
	localparam int          PPLSP_ADDR_W     = 8;
	localparam int          PPLSP_DATA_W     = 32;
	localparam int          PPLSP_CNT_W      = 16;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  PPLSP_OFS_INVERT   = 8'h00;
	localparam logic [7:0]  PPLSP_OFS_COMPLY   = 8'h04;
	localparam logic [7:0]  PPLSP_OFS_TXQUIET  = 8'h08;
	localparam logic [7:0]  PPLSP_OFS_POWER    = 8'h0c;
	localparam logic [7:0]  PPLSP_OFS_DETECT   = 8'h10;
	localparam logic [7:0]  PPLSP_OFS_LANESTAT = 8'h14;
	localparam logic [7:0]  PPLSP_OFS_IRQSTAT  = 8'h18;
	localparam logic [7:0]  PPLSP_OFS_IRQMASK  = 8'h1c;
	localparam logic [7:0]  PPLSP_OFS_COND     = 8'h20;
	localparam logic [7:0]  PPLSP_OFS_CLKCNT   = 8'h24;

	// ----------------------------------------------------------------
	// Field bases inside status words
	// ----------------------------------------------------------------
	localparam int          PPLSP_FLD_A = 0;
	localparam int          PPLSP_FLD_B = 8;
	localparam int          PPLSP_FLD_C = 16;
	localparam int          PPLSP_FLD_D = 24;

	// ----------------------------------------------------------------
	// Codes
	// ----------------------------------------------------------------
	localparam logic [2:0]  PPLSP_COND_OK       = 3'h0;
	localparam logic [2:0]  PPLSP_COND_DETECTED = 3'h3;
	localparam logic [2:0]  PPLSP_COND_DEC_ERR  = 3'h4;
	localparam logic [1:0]  PPLSP_PWR_P0        = 2'h0;
	localparam logic [1:0]  PPLSP_PWR_P0S       = 2'h1;
	localparam logic [1:0]  PPLSP_PWR_P1        = 2'h2;
	localparam logic [1:0]  PPLSP_PWR_RSVD      = 2'h3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] PPLSP_RST_ZERO      = 32'h0000_0000;
	localparam logic [7:0]  PPLSP_RST_TXQUIET   = 8'hff;
	localparam logic [15:0] PPLSP_RST_POWER     = 16'h0000;

endpackage : pplsp_pkg

// ---- design/pplsp_lane.sv ----
// One lane of the symbol port: data registers, idle synchroniser, event detection
module pplsp_lane
	import pplsp_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_sync_b,
	input  wire logic [15:0] user_tx_word,
	input  wire logic [1:0]  user_tx_kind,
	input  wire logic [15:0] rx_lane_word,
	input  wire logic [1:0]  rx_symbol_kind,
	input  wire logic        rx_symbol_locked,
	input  wire logic [2:0]  rx_lane_condition,
	input  wire logic        rx_line_quiet,
	input  wire logic        phy_op_done,
	input  wire logic        lane_channel_bonded,
	output logic      [15:0] tx_lane_word,
	output logic      [1:0]  tx_symbol_kind,
	output logic      [15:0] user_rx_word,
	output logic      [1:0]  user_rx_kind,
	output logic             user_rx_valid,
	output logic             quiet_synced,
	output logic             bonded,
	output logic             done_event,
	output logic             error_event,
	output logic             detect_event,
	output logic      [2:0]  cond_held
);

	typedef struct packed {
		logic        q1;
		logic        q2;
		logic [15:0] tx_word;
		logic [1:0]  tx_kind;
		logic [15:0] rx_word;
		logic [1:0]  rx_kind;
		logic        rx_valid;
		logic        bonded;
		logic        done;
		logic        err;
		logic        det;
		logic [2:0]  cond;
	} pplsp_lane_state_t;

	pplsp_lane_state_t s;
	pplsp_lane_state_t next_s;

	always_comb
	begin
		next_s          = s;
		next_s.q1       = rx_line_quiet;
		next_s.q2       = s.q1;
		next_s.tx_word  = user_tx_word;
		next_s.tx_kind  = user_tx_kind;
		next_s.rx_valid = rx_symbol_locked;
		next_s.rx_word  = rx_symbol_locked ? rx_lane_word : 16'h0000;
		next_s.rx_kind  = rx_symbol_locked ? rx_symbol_kind : 2'h0;
		next_s.bonded   = lane_channel_bonded;
		next_s.done     = phy_op_done;
		next_s.err      = rx_symbol_locked && (rx_lane_condition >= PPLSP_COND_DEC_ERR);
		next_s.det      = phy_op_done && (rx_lane_condition == PPLSP_COND_DETECTED);
		if (rx_symbol_locked || phy_op_done)
		begin
			next_s.cond = rx_lane_condition;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign tx_lane_word   = s.tx_word;
	assign tx_symbol_kind = s.tx_kind;
	assign user_rx_word   = s.rx_word;
	assign user_rx_kind   = s.rx_kind;
	assign user_rx_valid  = s.rx_valid;
	assign quiet_synced   = s.q2;
	assign bonded         = s.bonded;
	assign done_event     = s.done;
	assign error_event    = s.err;
	assign detect_event   = s.det;
	assign cond_held      = s.cond;

endmodule : pplsp_lane

// ---- design/pplsp_top.sv ----
// Per-lane symbol port toward the serial transceivers, with register port and interrupt
//
// The strobed register port and the placing of the registers are this design's own decisions.
module pplsp_top
	import pplsp_pkg::*;
#(
	parameter int LANES = PPLSP_LANES_DEF
)
(
	input  wire logic                    clock,
	input  wire logic                    rst_b,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic      [31:0]             reg_rdata,
	output logic                         irq,
	input  wire logic                    lane_interface_clock,
	input  wire logic [LANES-1:0][15:0]  user_tx_word,
	input  wire logic [LANES-1:0][1:0]   user_tx_kind,
	output logic      [LANES-1:0][15:0]  user_rx_word,
	output logic      [LANES-1:0][1:0]   user_rx_kind,
	output logic      [LANES-1:0]        user_rx_valid,
	input  wire logic [LANES-1:0]        lane_channel_bonded,
	input  wire logic [LANES-1:0][1:0]   rx_symbol_kind,
	input  wire logic [LANES-1:0][15:0]  rx_lane_word,
	input  wire logic [LANES-1:0]        rx_line_quiet,
	input  wire logic [LANES-1:0]        phy_op_done,
	output logic      [LANES-1:0]        rx_invert_request,
	input  wire logic [LANES-1:0][2:0]   rx_lane_condition,
	input  wire logic [LANES-1:0]        rx_symbol_locked,
	output logic      [LANES-1:0][1:0]   tx_symbol_kind,
	output logic      [LANES-1:0]        tx_force_neg_disparity,
	output logic      [LANES-1:0][15:0]  tx_lane_word,
	output logic      [LANES-1:0]        tx_line_quiet,
	output logic      [LANES-1:0][1:0]   tx_power_state,
	output logic                         far_end_detect_request
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (LANES < 1 || LANES > PPLSP_LANES_MAX)
	begin : g_bad_lanes
		$error("LANES must lie between one and eight");
	end

	if (PPLSP_PWR_W * LANES > $bits(PPLSP_RST_POWER))
	begin : g_bad_power
		$error("power codes of all lanes must fit the power register");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Accept a new power code per lane unless it is the reserved code
	function automatic logic [15:0] pplsp_power_merge(
		input logic [15:0] old_val,
		input logic [31:0] wr_val
	);
		logic [15:0] res;
		res = old_val;
		for (int i = 0; i < LANES; i++)
		begin
			if (wr_val[i*PPLSP_PWR_W +: PPLSP_PWR_W] != PPLSP_PWR_RSVD)
			begin
				res[i*PPLSP_PWR_W +: PPLSP_PWR_W] = wr_val[i*PPLSP_PWR_W +: PPLSP_PWR_W];
			end
		end
		return res;
	endfunction : pplsp_power_merge

	// Place a lane vector into one byte field of a 32-bit word
	function automatic logic [31:0] pplsp_field(
		input logic [7:0] lanes_val,
		input int         base
	);
		logic [31:0] res;
		res = PPLSP_RST_ZERO;
		for (int i = 0; i < LANES; i++)
		begin
			res[base + i] = lanes_val[i];
		end
		return res;
	endfunction : pplsp_field

	// Widen a vector of LANES bits to the full eight-lane field
	function automatic logic [7:0] pplsp_pad_lanes(
		input logic [LANES-1:0] lanes_val
	);
		logic [7:0] res;
		res = 8'h00;
		for (int i = 0; i < LANES; i++)
		begin
			res[i] = lanes_val[i];
		end
		return res;
	endfunction : pplsp_pad_lanes

	// Compliance may only force disparity on a sending lane in normal power
	function automatic logic [7:0] pplsp_comply_gate(
		input logic [7:0]  comply_val,
		input logic [7:0]  quiet_val,
		input logic [15:0] power_val
	);
		logic [7:0] res;
		res = 8'h00;
		for (int i = 0; i < LANES; i++)
		begin
			res[i] = comply_val[i] && !quiet_val[i]
			      && (power_val[i*PPLSP_PWR_W +: PPLSP_PWR_W] == PPLSP_PWR_P0);
		end
		return res;
	endfunction : pplsp_comply_gate

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_b;
	logic rst_sync_b;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// ----------------------------------------------------------------
	// Lanes
	// ----------------------------------------------------------------
	logic [7:0]      quiet_synced;
	logic [7:0]      bonded;
	logic [7:0]      done_event;
	logic [7:0]      error_event;
	logic [7:0]      detect_event;
	logic [7:0][2:0] cond_held;

	for (genvar g = 0; g < PPLSP_LANES_MAX; g++)
	begin : g_lane
		if (g < LANES)
		begin : g_used
			pplsp_lane u_lane (
				.clock               (clock),
				.rst_sync_b          (rst_sync_b),
				.user_tx_word        (user_tx_word[g]),
				.user_tx_kind        (user_tx_kind[g]),
				.rx_lane_word        (rx_lane_word[g]),
				.rx_symbol_kind      (rx_symbol_kind[g]),
				.rx_symbol_locked    (rx_symbol_locked[g]),
				.rx_lane_condition   (rx_lane_condition[g]),
				.rx_line_quiet       (rx_line_quiet[g]),
				.phy_op_done         (phy_op_done[g]),
				.lane_channel_bonded (lane_channel_bonded[g]),
				.tx_lane_word        (tx_lane_word[g]),
				.tx_symbol_kind      (tx_symbol_kind[g]),
				.user_rx_word        (user_rx_word[g]),
				.user_rx_kind        (user_rx_kind[g]),
				.user_rx_valid       (user_rx_valid[g]),
				.quiet_synced        (quiet_synced[g]),
				.bonded              (bonded[g]),
				.done_event          (done_event[g]),
				.error_event         (error_event[g]),
				.detect_event        (detect_event[g]),
				.cond_held           (cond_held[g])
			);
		end
		else
		begin : g_unused
			assign quiet_synced[g] = 1'b0;
			assign bonded[g]       = 1'b0;
			assign done_event[g]   = 1'b0;
			assign error_event[g]  = 1'b0;
			assign detect_event[g] = 1'b0;
			assign cond_held[g]    = PPLSP_COND_OK;
		end
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  invert;
		logic [7:0]  comply;
		logic [7:0]  txquiet;
		logic [15:0] power;
		logic        detect;
		logic [7:0]  quiet_prev;
		logic [31:0] irq_status;
		logic [31:0] irq_mask;
		logic [31:0] rdata;
		logic        lclk_s1;
		logic        lclk_s2;
		logic        lclk_s3;
		logic [15:0] lclk_count;
		logic [7:0]  force_neg;
		logic        irq;
	} pplsp_top_state_t;

	localparam pplsp_top_state_t PPLSP_TOP_RST = '{
		txquiet    : PPLSP_RST_TXQUIET,
		power      : PPLSP_RST_POWER,
		irq_status : PPLSP_RST_ZERO,
		irq_mask   : PPLSP_RST_ZERO,
		default    : '0
	};

	// Read value of one register; unmapped addresses read as zero
	function automatic logic [31:0] pplsp_read_word(
		input logic [7:0]       addr,
		input pplsp_top_state_t st,
		input logic [7:0]       valid_val,
		input logic [7:0]       bonded_val,
		input logic [7:0]       quiet_val,
		input logic [23:0]      cond_val
	);
		logic [31:0] res;
		res = PPLSP_RST_ZERO;
		case (addr)
			PPLSP_OFS_INVERT:   res = pplsp_field(st.invert, PPLSP_FLD_A);
			PPLSP_OFS_COMPLY:   res = pplsp_field(st.comply, PPLSP_FLD_A);
			PPLSP_OFS_TXQUIET:  res = pplsp_field(st.txquiet, PPLSP_FLD_A);
			PPLSP_OFS_POWER:    res = {16'h0000, st.power};
			PPLSP_OFS_DETECT:   res = {31'h0000_0000, st.detect};
			PPLSP_OFS_LANESTAT: res = pplsp_field(valid_val, PPLSP_FLD_A)
			                        | pplsp_field(bonded_val, PPLSP_FLD_B)
			                        | pplsp_field(quiet_val, PPLSP_FLD_C);
			PPLSP_OFS_IRQSTAT:  res = st.irq_status;
			PPLSP_OFS_IRQMASK:  res = st.irq_mask;
			PPLSP_OFS_COND:     res = {8'h00, cond_val};
			PPLSP_OFS_CLKCNT:   res = {16'h0000, st.lclk_count};
			default:            res = PPLSP_RST_ZERO;
		endcase
		return res;
	endfunction : pplsp_read_word

	pplsp_top_state_t s;
	pplsp_top_state_t next_s;

	logic [31:0] events;
	logic [31:0] rd_val;
	logic [7:0]  quiet_rise;

	always_comb
	begin
		quiet_rise     = quiet_synced & ~s.quiet_prev;
		events         = pplsp_field(done_event, PPLSP_FLD_A)
		               | pplsp_field(error_event, PPLSP_FLD_B)
		               | pplsp_field(detect_event, PPLSP_FLD_C)
		               | pplsp_field(quiet_rise, PPLSP_FLD_D);
		rd_val         = pplsp_read_word(reg_addr, s, pplsp_pad_lanes(user_rx_valid), bonded,
		                                 quiet_synced, cond_held);

		next_s            = s;
		next_s.quiet_prev = quiet_synced;
		next_s.rdata      = reg_read ? rd_val : PPLSP_RST_ZERO;
		next_s.lclk_s1    = lane_interface_clock;
		next_s.lclk_s2    = s.lclk_s1;
		next_s.lclk_s3    = s.lclk_s2;
		if (s.lclk_s2 && !s.lclk_s3)
		begin
			next_s.lclk_count = s.lclk_count + 16'h0001;
		end

		// Read clears status; a new event in the same cycle still lands
		if (reg_read && reg_addr == PPLSP_OFS_IRQSTAT)
		begin
			next_s.irq_status = events;
		end
		else
		begin
			next_s.irq_status = s.irq_status | events;
		end

		// Any completion pulse ends an outstanding detect or loopback request
		if (|done_event)
		begin
			next_s.detect = 1'b0;
		end

		if (reg_write)
		begin
			case (reg_addr)
				PPLSP_OFS_INVERT:  next_s.invert  = reg_wdata[7:0];
				PPLSP_OFS_COMPLY:  next_s.comply  = reg_wdata[7:0];
				PPLSP_OFS_TXQUIET: next_s.txquiet = reg_wdata[7:0];
				PPLSP_OFS_POWER:   next_s.power   = pplsp_power_merge(s.power, reg_wdata);
				PPLSP_OFS_DETECT:  next_s.detect  = reg_wdata[0] && !(|done_event);
				PPLSP_OFS_IRQMASK: next_s.irq_mask = reg_wdata;
				default:           next_s.detect  = next_s.detect;
			endcase
		end

		// Outputs come from the settled next state, so a write shows in the same cycle as its register
		next_s.force_neg = pplsp_comply_gate(next_s.comply, next_s.txquiet, next_s.power);
		next_s.irq       = |(next_s.irq_status & next_s.irq_mask);
	end

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			s <= PPLSP_TOP_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata              = s.rdata;
	assign irq                    = s.irq;
	assign far_end_detect_request = s.detect;

	always_comb
	begin
		for (int i = 0; i < LANES; i++)
		begin
			rx_invert_request[i]      = s.invert[i];
			tx_line_quiet[i]          = s.txquiet[i];
			tx_power_state[i]         = s.power[i*PPLSP_PWR_W +: PPLSP_PWR_W];
			tx_force_neg_disparity[i] = s.force_neg[i];
		end
	end

endmodule : pplsp_top

// ---- dv/pplsp_props.sv ----
// Port checker for the per-lane symbol port top
module pplsp_props
	import pplsp_pkg::*;
#(
	parameter int LANES = PPLSP_LANES_DEF
)
(
	input wire logic                   clock,
	input wire logic                   rst_b,
	input wire logic                   reg_read,
	input wire logic [31:0]            reg_rdata,
	input wire logic                   irq,
	input wire logic [LANES-1:0][15:0] user_tx_word,
	input wire logic [LANES-1:0][1:0]  user_tx_kind,
	input wire logic [LANES-1:0][15:0] tx_lane_word,
	input wire logic [LANES-1:0][1:0]  tx_symbol_kind,
	input wire logic [LANES-1:0]       rx_symbol_locked,
	input wire logic [LANES-1:0]       user_rx_valid,
	input wire logic [LANES-1:0]       phy_op_done,
	input wire logic [LANES-1:0]       tx_force_neg_disparity,
	input wire logic [LANES-1:0]       tx_line_quiet,
	input wire logic [LANES-1:0][1:0]  tx_power_state,
	input wire logic                   far_end_detect_request
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0]       up;
	logic [LANES-1:0] rsvd;
	logic [LANES-1:0] in_p0;

	// Counts edges since reset release, past the internal two-flop release
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;

	always_comb
		for (int i = 0; i < LANES; i++)
		begin
			rsvd[i] = &tx_power_state[i];
			in_p0[i] = tx_power_state[i] == PPLSP_PWR_P0;
		end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_TX_WORD: assert property (up == 2'h3 |=> tx_lane_word == $past(user_tx_word))
		else $error("transmit word is not the user word of the previous cycle");
	AST_TX_KIND: assert property (up == 2'h3 |=> tx_symbol_kind == $past(user_tx_kind))
		else $error("transmit kind is not the user kind of the previous cycle");
	AST_PWR_RSVD: assert property (rsvd == '0)
		else $error("reserved power state driven");
	AST_COMPLY_QUIET: assert property ((tx_force_neg_disparity & tx_line_quiet) == '0)
		else $error("compliance forced on a quiet lane");
	AST_COMPLY_P0: assert property ((tx_force_neg_disparity & ~in_p0) == '0)
		else $error("compliance forced outside normal power");
	AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	AST_RX_VALID: assert property (up == 2'h3 |=> user_rx_valid == $past(rx_symbol_locked))
		else $error("receive valid does not follow lock");
	AST_DET_DROP: assert property (far_end_detect_request && phy_op_done != '0
		|-> ##[1:4] !far_end_detect_request)
		else $error("detect request held after completion");

	COV_DETECT: cover property (far_end_detect_request && phy_op_done != '0);
	COV_IRQ: cover property ($rose(irq));
	COV_COMPLY: cover property (tx_force_neg_disparity != '0);
endmodule : pplsp_props

bind pplsp_top pplsp_props #(.LANES(LANES)) u_pplsp_props (.clock, .rst_b, .reg_read,
	.reg_rdata, .irq, .user_tx_word, .user_tx_kind, .tx_lane_word, .tx_symbol_kind,
	.rx_symbol_locked, .user_rx_valid, .phy_op_done, .tx_force_neg_disparity,
	.tx_line_quiet, .tx_power_state, .far_end_detect_request);

// ---- dv/pplsp_xcvr_model.sv ----
// Behavioural transceiver coding sublayer for every lane
module pplsp_xcvr_model
	import pplsp_pkg::*;
#(
	parameter int LANES = 8,
	parameter int LAG   = 3
)
(
	input  wire logic                   clock,
	input  wire logic [LANES-1:0]       lock_en,
	input  wire logic [LANES-1:0]       quiet_en,
	input  wire logic                   err_en,
	input  wire logic [LANES-1:0][1:0]  tx_power_state,
	input  wire logic                   far_end_detect_request,
	output logic      [LANES-1:0]       lane_channel_bonded,
	output logic      [LANES-1:0][1:0]  rx_symbol_kind,
	output logic      [LANES-1:0][15:0] rx_lane_word,
	output logic      [LANES-1:0]       rx_line_quiet,
	output logic      [LANES-1:0]       phy_op_done,
	output logic      [LANES-1:0][2:0]  rx_lane_condition,
	output logic      [LANES-1:0]       rx_symbol_locked
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0]           cnt = 16'h0;
	logic [LANES-1:0][1:0] pwr_q = '0;
	logic                  det_q = 1'b0;
	int                    wait_n = 0;

	initial
		{lane_channel_bonded, rx_symbol_kind, rx_lane_word, rx_line_quiet, phy_op_done,
			rx_lane_condition, rx_symbol_locked} = '0;

	// Idle detection runs off its own analogue timing, not the interface clock
	always @(quiet_en)
		rx_line_quiet <= #7 quiet_en;

	always @(posedge clock)
	begin
		cnt <= cnt + 16'h1;
		det_q <= far_end_detect_request;
		pwr_q <= tx_power_state;
		rx_symbol_locked <= lock_en;
		lane_channel_bonded <= lock_en;
		if (far_end_detect_request && !det_q && tx_power_state[0] == PPLSP_PWR_P1)
			wait_n <= LAG;
		else if (wait_n > 0)
			wait_n <= wait_n - 1;
		for (int i = 0; i < LANES; i++)
		begin
			// Unlocked lanes carry garbage that changes every cycle
			rx_lane_word[i] <= lock_en[i] ? cnt + 16'(i) : ~rx_lane_word[i];
			rx_symbol_kind[i] <= lock_en[i] ? cnt[1:0] : ~rx_symbol_kind[i];
			phy_op_done[i] <= wait_n == 1 || tx_power_state[i] != pwr_q[i];
			rx_lane_condition[i] <= wait_n == 1 ? PPLSP_COND_DETECTED :
				err_en ? PPLSP_COND_DEC_ERR : PPLSP_COND_OK;
		end
	end
endmodule : pplsp_xcvr_model

// ---- dv/tb.sv ----
// Testbench for the per-lane symbol port with a transceiver model
module tb
	import pplsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int L = 8;
	logic               clock = 1'b0;
	logic               rst_b = 1'b0;
	logic               lane_interface_clock = 1'b0;
	logic [7:0]         reg_addr = 8'h0;
	logic [31:0]        reg_wdata = 32'h0;
	logic               reg_write = 1'b0;
	logic               reg_read = 1'b0;
	logic [31:0]        reg_rdata, rd_val;
	logic               irq, far_end_detect_request, err_en = 1'b0;
	logic [L-1:0][15:0] user_tx_word = '0, user_rx_word, rx_lane_word, tx_lane_word;
	logic [L-1:0][1:0]  user_tx_kind = '0, user_rx_kind, rx_symbol_kind, tx_symbol_kind;
	logic [L-1:0][1:0]  tx_power_state;
	logic [L-1:0][2:0]  rx_lane_condition;
	logic [L-1:0]       lock_en = '0, quiet_en = '0, user_rx_valid, lane_channel_bonded;
	logic [L-1:0]       rx_line_quiet, phy_op_done, rx_invert_request, rx_symbol_locked;
	logic [L-1:0]       tx_force_neg_disparity, tx_line_quiet;
	logic [17:0]        snap;
	int                 bad_count = 0;
	int                 checks = 0;

	pplsp_top #(.LANES(L)) u_pplsp_top (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .irq, .lane_interface_clock, .user_tx_word, .user_tx_kind,
		.user_rx_word, .user_rx_kind, .user_rx_valid, .lane_channel_bonded, .rx_symbol_kind,
		.rx_lane_word, .rx_line_quiet, .phy_op_done, .rx_invert_request, .rx_lane_condition,
		.rx_symbol_locked, .tx_symbol_kind, .tx_force_neg_disparity, .tx_lane_word,
		.tx_line_quiet, .tx_power_state, .far_end_detect_request);
	pplsp_xcvr_model #(.LANES(L)) u_pplsp_xcvr_model (.clock, .lock_en, .quiet_en, .err_en,
		.tx_power_state, .far_end_detect_request, .lane_channel_bonded, .rx_symbol_kind,
		.rx_lane_word, .rx_line_quiet, .phy_op_done, .rx_lane_condition, .rx_symbol_locked);

	always #12.5 clock = ~clock;
	initial
	begin
		#7;
		forever #100 lane_interface_clock = ~lane_interface_clock;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk($sformatf("register %h", a), exp, rd_val);
	endtask : rdc
	task automatic report_and_stop;
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	initial
	begin
		#100000;
		bad_count++;
		report_and_stop();
	end

	initial
	begin
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		step(4);
		rdc(PPLSP_OFS_TXQUIET, 32'hff);
		rdc(PPLSP_OFS_POWER, 32'h0);
		rdc(8'h40, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clock);
			for (int i = 0; i < L; i++)
				user_tx_word[i] <= 16'(16'h1111 * i + k);
			user_tx_kind <= {8{2'(k)}};
			step(1);
			for (int i = 0; i < L; i++)
				chk("tx lane", {14'h0, 2'(k), 16'(16'h1111 * i + k)}, {14'h0, tx_symbol_kind[i], tx_lane_word[i]});
		end
		wr(PPLSP_OFS_INVERT, 32'ha5);
		step(0);
		chk("invert", 32'ha5, 32'(rx_invert_request));
		for (int c = 0; c < 3; c++)
		begin
			wr(PPLSP_OFS_POWER, 32'({8{2'(c)}}));
			step(0);
			chk("power", 32'({8{2'(c)}}), 32'(tx_power_state));
		end
		wr(PPLSP_OFS_POWER, 32'hfff4);
		step(4);
		chk("power", 32'haaa4, 32'(tx_power_state));
		rd(PPLSP_OFS_IRQSTAT);
		wr(PPLSP_OFS_IRQMASK, 32'hff);
		wr(PPLSP_OFS_POWER, 32'h5555);
		step(4);
		chk("irq", 32'h1, 32'(irq));
		rdc(PPLSP_OFS_IRQSTAT, 32'hfd);
		step(2);
		chk("irq", 32'h0, 32'(irq));
		wr(PPLSP_OFS_IRQMASK, 32'h0);
		wr(PPLSP_OFS_POWER, 32'haaaa);
		step(4);
		chk("irq", 32'h0, 32'(irq));
		rdc(PPLSP_OFS_IRQSTAT, 32'hff);
		wr(PPLSP_OFS_DETECT, 32'h1);
		step(0);
		chk("detect", 32'h1, 32'(far_end_detect_request));
		step(12);
		chk("detect", 32'h0, 32'(far_end_detect_request));
		rdc(PPLSP_OFS_IRQSTAT, 32'hff00ff);
		rdc(PPLSP_OFS_COND, 32'h6db6db);
		wr(PPLSP_OFS_POWER, 32'h0);
		step(4);
		rd(PPLSP_OFS_IRQSTAT);
		wr(PPLSP_OFS_DETECT, 32'h1);
		step(12);
		chk("loopback", 32'h1, 32'(far_end_detect_request));
		rdc(PPLSP_OFS_IRQSTAT, 32'h0);
		wr(PPLSP_OFS_DETECT, 32'h0);
		wr(PPLSP_OFS_TXQUIET, 32'h0);
		wr(PPLSP_OFS_COMPLY, 32'h0f);
		step(0);
		chk("comply", 32'h0f, 32'(tx_force_neg_disparity));
		wr(PPLSP_OFS_TXQUIET, 32'h03);
		step(0);
		chk("comply", 32'h0c, 32'(tx_force_neg_disparity));
		chk("tx quiet", 32'h03, 32'(tx_line_quiet));
		@(posedge clock);
		lock_en <= '1;
		step(3);
		snap = {rx_symbol_kind[5], rx_lane_word[5]};
		step(1);
		chk("rx lane", 32'(snap), 32'({user_rx_kind[5], user_rx_word[5]}));
		rdc(PPLSP_OFS_LANESTAT, 32'hffff);
		@(posedge clock);
		err_en <= 1'b1;
		@(posedge clock);
		err_en <= 1'b0;
		step(4);
		rdc(PPLSP_OFS_IRQSTAT, 32'hff00);
		@(posedge clock);
		lock_en <= '0;
		step(3);
		chk("rx valid", 32'h0, 32'({user_rx_valid, user_rx_word[0]}));
		@(posedge clock);
		quiet_en <= 8'h3c;
		step(6);
		rdc(PPLSP_OFS_LANESTAT, 32'h3c0000);
		rdc(PPLSP_OFS_IRQSTAT, 32'h3c000000);
		rd(PPLSP_OFS_CLKCNT);
		snap = 18'(rd_val[15:0]);
		step(158);
		rd(PPLSP_OFS_CLKCNT);
		chk("link edges", 32'h14, 32'(rd_val[15:0] - snap[15:0]));
		report_and_stop();
	end
endmodule : tb
